//--- pkg/pwm_defs.vh
// register map, field layout and timing constants of the dual pwm block
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH

// register indices; byte address is four times the index
`define IDX_CONTROL 6'h0C
`define IDX_CH0_WIDTH 6'h0D
`define IDX_CH1_WIDTH 6'h0E
`define IDX_STATUS 6'h0F

// control register fields
`define CTL_RUN_BIT 0
`define CTL_MODE_LO 1
`define CTL_MODE_HI 2
`define CTL_EN_A_BIT 3
`define CTL_EN_B_BIT 4

// reset values
`define CONTROL_RESET 8'h00
`define WIDTH_RESET 8'h00

// period mode encodings
`define MODE_8BIT 2'h0
`define MODE_7BIT 2'h1
`define MODE_6BIT 2'h2
`define MODE_RSVD 2'h3

// last count of each period (periods of 256, 128 and 64 clocks)
`define LAST_8BIT 8'hFF
`define LAST_7BIT 8'h7F
`define LAST_6BIT 8'h3F

// clock period of the source oscillator in ns
`define SRC_CLK_NS 40

`endif

//--- core/dual_channel_fast_pwm.v
// dual channel fast pwm generator with apb register access
`timescale 1ns/100ps
`include "pwm_defs.vh"

module dual_channel_fast_pwm
(
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  output wire O_PWM_OUT_A,
  output wire O_PWM_OUT_B
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------

  wire [5:0] word_idx;
  wire acc_phase;
  wire wr_en;
  wire hit_ctl;
  wire hit_ch0;
  wire hit_ch1;
  wire hit_sts;
  wire mapped;

  // word index from byte address; low two bits ignored
  assign word_idx = I_PADDR[7:2];
  assign acc_phase = I_PSEL & I_PENABLE;
  assign hit_ctl = (word_idx == `IDX_CONTROL);
  assign hit_ch0 = (word_idx == `IDX_CH0_WIDTH);
  assign hit_ch1 = (word_idx == `IDX_CH1_WIDTH);
  assign hit_sts = (word_idx == `IDX_STATUS);
  assign mapped = hit_ctl | hit_ch0 | hit_ch1 | hit_sts;
  assign wr_en = acc_phase & I_PWRITE;

  // zero wait states; unmapped addresses answer with an error
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc_phase & ~mapped;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------

  reg run_q;
  reg [1:0] mode_q;
  reg en_a_q;
  reg en_b_q;
  wire ctl_wr;
  wire run_wr;

  assign ctl_wr = wr_en & hit_ctl;
  assign run_wr = I_PWDATA[`CTL_RUN_BIT];

  // a write with run low stops the unit and clears both enables,
  // which doubles as the software reset of all but the mode field and read data
  always @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      run_q <= 1'b0;
      mode_q <= `MODE_8BIT;
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
    end
    else if (ctl_wr)
    begin
      run_q <= run_wr;
      if (!run_wr)
      begin
        en_a_q <= 1'b0;
        en_b_q <= 1'b0;
      end
      else
      begin
        en_a_q <= I_PWDATA[`CTL_EN_A_BIT];
        en_b_q <= I_PWDATA[`CTL_EN_B_BIT];
      end
      // mode is only taken while stopped or while stopping
      if (!run_q || !run_wr)
      begin
        mode_q <= I_PWDATA[`CTL_MODE_HI:`CTL_MODE_LO];
      end
    end
  end

  // ---------------------------------------------------------------
  // shared period counter
  // ---------------------------------------------------------------

  reg [7:0] cnt_q;
  reg [7:0] last_cnt;
  wire wrap;

  // one mode for both channels; reserved code runs as 8-bit
  always @*
  begin
    case (mode_q)
      `MODE_8BIT: last_cnt = `LAST_8BIT;
      `MODE_7BIT: last_cnt = `LAST_7BIT;
      `MODE_6BIT: last_cnt = `LAST_6BIT;
      default: last_cnt = `LAST_8BIT;
    endcase
  end

  assign wrap = run_q & (cnt_q == last_cnt);

  // counter held at zero while stopped
  always @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      cnt_q <= 8'h00;
    end
    else if (!run_q)
    begin
      cnt_q <= 8'h00;
    end
    else if (wrap)
    begin
      cnt_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // per channel width, dither and output stage
  // ---------------------------------------------------------------

  wire [1:0] ch_hit;
  wire [1:0] ch_en;
  wire [15:0] ch_data;
  wire [1:0] ch_out;

  assign ch_hit = {hit_ch1, hit_ch0};
  assign ch_en = {en_b_q, en_a_q};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : chan
      reg [7:0] data_q;
      reg [8:0] wid_q;
      reg half_q;
      reg acc_q;
      reg pos_q;
      reg neg_q;
      reg [8:0] wid_d;
      reg half_d;
      reg acc_d;
      reg [2:0] quarters;

      // data register; writes only land while running, and a
      // stop wipes it along with the control bits
      always @(posedge I_CLK)
      begin
        if (!I_RESET_N)
        begin
          data_q <= `WIDTH_RESET;
        end
        else if (ctl_wr && !run_wr)
        begin
          data_q <= `WIDTH_RESET;
        end
        else if (wr_en && ch_hit[g] && run_q)
        begin
          data_q <= I_PWDATA[7:0];
        end
      end

      // width for the coming period, in whole plus half clocks
      always @*
      begin
        quarters = {2'b00, acc_q} + {1'b0, data_q[1:0]};
        wid_d = {1'b0, data_q};
        half_d = 1'b0;
        acc_d = 1'b0;
        case (mode_q)
          `MODE_7BIT:
          begin
            wid_d = {2'b00, data_q[7:1]};
            half_d = data_q[0];
          end
          `MODE_6BIT:
          begin
            // carry a quarter residue so the average step is
            // a quarter clock while each pulse gains 0, 1/2 or 1
            wid_d = {3'b000, data_q[7:2]} + {8'h00, quarters[2]};
            half_d = quarters[1];
            acc_d = quarters[0];
          end
          default:
          begin
            wid_d = {1'b0, data_q};
          end
        endcase
      end

      // width latched only at the boundary, or freely while
      // stopped so the first period is already right
      always @(posedge I_CLK)
      begin
        if (!I_RESET_N)
        begin
          wid_q <= 9'h000;
          half_q <= 1'b0;
          acc_q <= 1'b0;
        end
        else if (!run_q || wrap)
        begin
          wid_q <= wid_d;
          half_q <= half_d;
          acc_q <= run_q ? acc_d : 1'b0;
        end
      end

      // low from period start for the width, high afterwards
      always @(posedge I_CLK)
      begin
        if (!I_RESET_N)
        begin
          pos_q <= 1'b1;
        end
        else
        begin
          pos_q <= ~(run_q & ch_en[g] & ({1'b0, cnt_q} < wid_q));
        end
      end

      // falling-edge copy delays the rising edge by half a clock
      always @(negedge I_CLK)
      begin
        if (!I_RESET_N)
        begin
          neg_q <= 1'b1;
        end
        else
        begin
          neg_q <= pos_q;
        end
      end

      assign ch_out[g] = half_q ? (pos_q & neg_q) : pos_q;
      assign ch_data[8*g+7:8*g] = data_q;
    end
  endgenerate

  // stopped or disabled channels rest high
  assign O_PWM_OUT_A = ch_out[0];
  assign O_PWM_OUT_B = ch_out[1];

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------

  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h00000000;
    if (hit_ctl)
    begin
      rd_d[`CTL_RUN_BIT] = run_q;
      rd_d[`CTL_MODE_HI:`CTL_MODE_LO] = mode_q;
      rd_d[`CTL_EN_A_BIT] = en_a_q;
      rd_d[`CTL_EN_B_BIT] = en_b_q;
    end
    else if (hit_ch0)
    begin
      rd_d[7:0] = ch_data[7:0];
    end
    else if (hit_ch1)
    begin
      rd_d[7:0] = ch_data[15:8];
    end
    else if (hit_sts)
    begin
      rd_d[7:0] = cnt_q;
      rd_d[9:8] = ch_out;
    end
  end

  // read data registered in the setup phase, valid in access
  always @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      O_PRDATA <= 32'h00000000;
    end
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
    begin
      O_PRDATA <= rd_d;
    end
  end

endmodule

//--- sim/pwm_monitor.sv
// bus and pin timing checker for the dual pwm block
`timescale 1ns/100ps
module pwm_monitor
(
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire O_PWM_OUT_A,
  input wire O_PWM_OUT_B
);
  // -------
  // checks
  // -------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // access phase of any transfer
  wire acc = I_PSEL && I_PENABLE;
  AST_READY: assert property (acc |-> O_PREADY)
    else $error("access without ready");
  AST_ERR_IDLE: assert property (!acc |-> !O_PSLVERR)
    else $error("error outside access");
  AST_ERR_MAP: assert property (acc |-> O_PSLVERR == (I_PADDR[7:4] != 4'h3))
    else $error("error flag wrong for address");
  AST_UPPER_ZERO: assert property (acc && !I_PWRITE |->
    O_PRDATA[31:10] == 22'h0)
    else $error("upper read bits set");
  AST_RD_HOLD: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE) |=>
    $stable(O_PRDATA))
    else $error("read data moved");
  // a stop write must park both pins high
  AST_STOP_HIGH: assert property (acc && I_PWRITE &&
    I_PADDR[7:2] == 6'h0C && !I_PWDATA[0] |->
    ##2 (O_PWM_OUT_A && O_PWM_OUT_B)[*2])
    else $error("pin low after stop");
  AST_LOW_A: assert property ($fell(O_PWM_OUT_A) |->
    ##[1:256] O_PWM_OUT_A)
    else $error("pulse a too long");
  AST_LOW_B: assert property ($fell(O_PWM_OUT_B) |->
    ##[1:256] O_PWM_OUT_B)
    else $error("pulse b too long");
endmodule
bind dual_channel_fast_pwm pwm_monitor u_mon (.I_CLK(I_CLK),
  .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_PWM_OUT_A(O_PWM_OUT_A), .O_PWM_OUT_B(O_PWM_OUT_B));

//--- sim/testbench.sv
// self-checking bench for the dual pwm block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, out_a, out_b;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] rd;
  logic er;
  int lo, per, lo2;
  // widths per mode and expected low/period times in half clocks
  logic [7:0] da [4] = '{8'h10, 8'hE7, 8'h13, 8'h10};
  logic [7:0] db [4] = '{8'hF0, 8'h10, 8'hF0, 8'hF0};
  int sa [4] = '{64, 462, 19, 64};
  int sb [4] = '{960, 32, 240, 960};
  int pe [4] = '{512, 256, 128, 512};
  dual_channel_fast_pwm u_dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PWM_OUT_A(out_a), .O_PWM_OUT_B(out_b));
  // 40 ns clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  // ---------
  // helpers
  // ---------
  task check(input [31:0] s, input [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer; answer taken at the ready edge only
  task apb(input [7:0] a, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        n_fail++;
        report_and_stop();
      end
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // half clocks the pin stays at a level; sampled off both edges
  task span(input bit s, input bit lv, output int n);
    n = 0;
    while ((s ? out_b : out_a) === lv) // latch taken as one
    begin
      @(clk);
      #1;
      n++;
      if (n > 2000)
      begin
        n_fail++;
        report_and_stop();
      end
    end
  endtask
  task measure(input bit s);
    int h;
    span(s, 1'b0, h);
    span(s, 1'b1, h);
    span(s, 1'b0, lo);
    span(s, 1'b1, h);
    per = lo + h;
    span(s, 1'b0, lo2);
  endtask
  // ---------
  // scenarios
  // ---------
  task t_regs;
    apb(8'h30, 0, 32'h0);
    check(rd, 32'h0);
    apb(8'h34, 1, 32'h55);
    apb(8'h34, 0, 32'h0);
    check(rd, 32'h0);
    apb(8'h40, 0, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(8'h30, 1, 32'h1);
    apb(8'h34, 1, 32'hA5);
    apb(8'h38, 1, 32'h5A);
    apb(8'h34, 0, 32'h0);
    check(rd, 32'hA5);
    apb(8'h38, 0, 32'h0);
    check(rd, 32'h5A);
    $display("test regs done");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++)
    begin
      apb(8'h30, 1, {29'h0, m[1:0], 1'b0});
      apb(8'h30, 1, {29'h0, m[1:0], 1'b1});
      apb(8'h34, 1, {24'h0, da[m]});
      apb(8'h38, 1, {24'h0, db[m]});
      apb(8'h30, 1, {27'h0, 2'h3, m[1:0], 1'b1});
      apb(8'h30, 0, 32'h0);
      check(rd, {27'h0, 2'h3, m[1:0], 1'b1});
      measure(0);
      check(lo + lo2, sa[m]);
      check(per, pe[m]);
      measure(1);
      check(lo + lo2, sb[m]);
      check(per, pe[m]);
    end
    $display("test modes done");
  endtask
  task t_stop;
    int n;
    time t0;
    apb(8'h30, 1, 32'h0);
    apb(8'h30, 0, 32'h0);
    check(rd, 32'h0);
    apb(8'h34, 0, 32'h0);
    check(rd, 32'h0);
    apb(8'h3C, 0, 32'h0);
    check(rd, 32'h300);
    apb(8'h30, 1, 32'h9);
    apb(8'h34, 1, 32'h80);
    apb(8'h38, 1, 32'h80);
    n = 0;
    repeat (600)
    begin
      @(posedge clk);
      #1;
      n += (out_b !== 1'b1);
    end
    check(n, 0);
    measure(0);
    check(lo, 256);
    // a width written mid-pulse must not cut the running pulse
    span(0, 1'b1, n);
    t0 = $time;
    apb(8'h34, 1, 32'h40);
    span(0, 1'b0, n);
    check(int'(($time - t0) / 20), 256);
    measure(0);
    check(lo, 128);
    $display("test stop done");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_modes();
    t_stop();
    report_and_stop();
  end
endmodule
